// File: queue_pkg.sv
/*
 * Shared constants for the byte queue device and its controller.
 * Assumes both ends and the link interface import this package whole.
 */
package queue_pkg;

    // queue geometry
    localparam int QUEUE_DEPTH = 64;
    localparam int DATA_W = 8;
    localparam int CNT_W = 7;
    localparam int ADDR_W = 6;

    // device register offsets on the link
    localparam logic [ADDR_W-1:0] OFS_DATA = 6'h02;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h03;
    localparam logic [ADDR_W-1:0] OFS_FILL = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_IEN = 6'h06;
    localparam logic [ADDR_W-1:0] OFS_IRQ = 6'h07;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h09;
    localparam logic [ADDR_W-1:0] OFS_FAULT = 6'h0a;
    localparam logic [ADDR_W-1:0] OFS_WMARK = 6'h29;

    // device field positions and reset values
    localparam int BIT_NEAR_EMPTY = 0;
    localparam int BIT_NEAR_FULL = 1;
    localparam int BIT_IRQ = 3;
    localparam int BIT_FLUSH = 0;
    localparam int BIT_OVF = 4;
    localparam int BIT_SETSEL = 7;
    localparam logic [7:0] ALERT_BITS = 8'h03;
    localparam logic [7:0] WMARK_RESET = 8'h3e;
    localparam logic [7:0] IRQ_RESET = 8'h00;

    // controller register byte addresses on apb
    localparam logic [11:0] HOFS_REQ = 12'h000;
    localparam logic [11:0] HOFS_RESP = 12'h004;
    localparam logic [11:0] HOFS_ISTAT = 12'h008;
    localparam logic [11:0] HOFS_IMASK = 12'h00c;
    localparam logic [11:0] HOFS_ACCESS = 12'h010;

    // controller field positions
    localparam int REQ_WDATA_LSB = 0;
    localparam int REQ_ADDR_LSB = 8;
    localparam int REQ_DIR_BIT = 16;
    localparam int RESP_BUSY_BIT = 0;
    localparam int RESP_DATA_LSB = 8;
    localparam int RESP_DEVIRQ_BIT = 16;
    localparam int HIRQ_DONE = 0;
    localparam int HIRQ_DEV = 1;
    localparam int HIRQ_REFUSED = 2;
    localparam int ACC_WR_BIT = 0;
    localparam int ACC_RD_BIT = 1;
    localparam logic [1:0] ACCESS_RESET = 2'h3;

    // set or clear the selected bits, keyed by the top bit of the write
    function automatic logic [7:0] set_clear(input logic [7:0] old,
                                             input logic [7:0] wdata);
        logic [7:0] sel;
        sel = wdata & ALERT_BITS;
        set_clear = wdata[BIT_SETSEL] ? (old | sel) : (old & ~sel);
    endfunction : set_clear

endpackage : queue_pkg

// File: queue_link_if.sv
/*
 * Register link between the queue controller and the queue device.
 * Assumes one pclk domain for both ends; the bench joins the modports.
 */
`timescale 1ns/1ps
`default_nettype none

interface queue_link_if import queue_pkg::*;;
    logic [ADDR_W-1:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rvalid;
    logic irq;

    // the documented device answers register accesses
    modport dev (
        input reg_addr, reg_wr, reg_rd, reg_wdata,
        output reg_rdata, reg_rvalid, irq
    );

    // the controller issues register accesses
    modport ctl (
        output reg_addr, reg_wr, reg_rd, reg_wdata,
        input reg_rdata, reg_rvalid, irq
    );
endinterface : queue_link_if

`default_nettype wire

// File: queue_device.sv
/*
 * Byte queue device: 64-entry store, fill count, flush, overflow flag,
 * near-full and near-empty alerts with interrupt requests.
 * Assumes the controller and the internal engine share pclk, and that
 * they avoid pushing or popping in the same cycle as each other.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - one 64-byte queue serves both directions
// - host data write stores byte, advances write pointer
// - host data read returns byte, advances read pointer
// - fill count readable in bits 6..0
// - flush resets pointers, count, overflow
// - overflow bit 4 sticky until flush
// - near full when 64 minus count within threshold
// - near empty when count within threshold
// - near full shown in status bit 1
// - near empty shown in status bit 0
// - irq from enabled request bits 1 and 0
// - engine shares queue; host avoids disturbing it
// - host accesses only as each command permits
// - send-and-receive: host tracks direction
// - nv read: write arguments, then only read
// - summary irq is OR of enabled requests
// - threshold register resets to 3e
module queue_device import queue_pkg::*; #(
    parameter int DEPTH = QUEUE_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    queue_link_if.dev link,
    input wire logic eng_push,
    input wire logic [DATA_W-1:0] eng_wdata,
    input wire logic eng_pop,
    output logic [DATA_W-1:0] eng_rdata,
    output logic [CNT_W-1:0] eng_fill,
    output logic eng_near_full,
    output logic eng_near_empty
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

    // both alert flags for a given fill count and threshold
    function automatic logic [1:0] alerts(input logic [CNT_W-1:0] cnt,
                                          input logic [5:0] lvl);
        logic [CNT_W-1:0] room;
        logic [CNT_W-1:0] lvl_w;
        room = DEPTH_C - cnt;
        lvl_w = {1'b0, lvl};
        alerts = {room <= lvl_w, cnt <= lvl_w};
    endfunction : alerts

    // storage and state
    logic [DATA_W-1:0] mem [DEPTH];
    logic [PW-1:0] wptr_reg;
    logic [PW-1:0] wptr_next;
    logic [PW-1:0] rptr_reg;
    logic [PW-1:0] rptr_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic ovf_reg;
    logic ovf_next;
    logic [5:0] level_reg;
    logic [5:0] level_next;
    logic [7:0] ien_reg;
    logic [7:0] ien_next;
    logic [7:0] pend_reg;
    logic [7:0] pend_next;
    logic [1:0] flags_reg;
    logic [1:0] flags_next;
    logic irq_reg;
    logic irq_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic rvalid_reg;
    logic [DATA_W-1:0] eng_rdata_reg;

    // host access decode
    wire logic [ADDR_W-1:0] addr = link.reg_addr;
    wire logic [7:0] wdata = link.reg_wdata;
    wire logic host_wr_data = link.reg_wr & (addr == OFS_DATA);
    wire logic host_rd_data = link.reg_rd & (addr == OFS_DATA);
    wire logic wr_ien = link.reg_wr & (addr == OFS_IEN);
    wire logic wr_irq = link.reg_wr & (addr == OFS_IRQ);
    wire logic wr_wmark = link.reg_wr & (addr == OFS_WMARK);
    wire logic flush = link.reg_wr & (addr == OFS_CTRL) & wdata[BIT_FLUSH];

    // host has the port when both sides try in one cycle
    wire logic eng_push_eff = eng_push & ~host_wr_data;
    wire logic eng_pop_eff = eng_pop & ~host_rd_data;

    // merged push and pop into the single queue
    wire logic push_req = host_wr_data | eng_push_eff;
    wire logic pop_req = host_rd_data | eng_pop_eff;
    wire logic [DATA_W-1:0] push_data = host_wr_data ? wdata : eng_wdata;
    wire logic full = (count_reg == DEPTH_C);
    wire logic empty = (count_reg == '0);
    wire logic push_ok = push_req & ~full & ~flush;
    wire logic pop_ok = pop_req & ~empty & ~flush;
    wire logic overflow_evt = push_req & full & ~flush;
    wire logic [DATA_W-1:0] head = mem[rptr_reg];

    // pointer and fill count update
    assign wptr_next = flush ? '0 : (push_ok ? wptr_reg + 1'b1 : wptr_reg);
    assign rptr_next = flush ? '0 : (pop_ok ? rptr_reg + 1'b1 : rptr_reg);
    assign count_next = flush ? '0 :
        (count_reg + CNT_W'(push_ok) - CNT_W'(pop_ok));

    // overflow is sticky, flush alone clears it
    assign ovf_next = flush ? 1'b0 : (ovf_reg | overflow_evt);

    // threshold and alert flags track the next state exactly
    assign level_next = wr_wmark ? wdata[5:0] : level_reg;
    assign flags_next = alerts(count_next, level_next);

    // request bits: software set or clear, hardware set wins
    assign ien_next = wr_ien ? set_clear(ien_reg, wdata) : ien_reg;
    assign pend_next = (wr_irq ? set_clear(pend_reg, wdata) : pend_reg)
        | {6'h00, flags_reg};

    // summary interrupt from enabled requests only
    assign irq_next = |(pend_next & ien_next & ALERT_BITS);

    // register read selection, unmapped offsets read zero
    wire logic [7:0] status_val = {4'h0, irq_reg, 1'b0,
        flags_reg[1], flags_reg[0]};
    wire logic [7:0] fault_val = {3'h0, ovf_reg, 4'h0};
    wire logic [7:0] fill_val = {1'b0, count_reg};
    wire logic [7:0] data_val = empty ? 8'h00 : head;
    assign rdata_next =
        (addr == OFS_DATA) ? data_val :
        (addr == OFS_STATUS) ? status_val :
        (addr == OFS_FILL) ? fill_val :
        (addr == OFS_IEN) ? ien_reg :
        (addr == OFS_IRQ) ? pend_reg :
        (addr == OFS_FAULT) ? fault_val :
        (addr == OFS_WMARK) ? {2'b00, level_reg} :
        8'h00;

    // queue storage, no reset needed
    always_ff @(posedge pclk) begin
        if (push_ok) begin
            mem[wptr_reg] <= push_data;
        end
    end

    // queue pointers, count and overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
            ovf_reg <= 1'b0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            count_reg <= count_next;
            ovf_reg <= ovf_next;
        end
    end

    // configuration, alert flags and interrupt state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= WMARK_RESET[5:0];
            flags_reg <= 2'b01;
            ien_reg <= IRQ_RESET;
            pend_reg <= IRQ_RESET;
            irq_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
            flags_reg <= flags_next;
            ien_reg <= ien_next;
            pend_reg <= pend_next;
            irq_reg <= irq_next;
        end
    end

    // read answer one cycle after the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= link.reg_rd;
            if (link.reg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // engine pop data, held until its next successful pop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_rdata_reg <= 8'h00;
        end else if (eng_pop_eff & pop_ok) begin
            eng_rdata_reg <= head;
        end
    end

    // outputs straight from flip-flops
    assign link.reg_rdata = rdata_reg;
    assign link.reg_rvalid = rvalid_reg;
    assign link.irq = irq_reg;
    assign eng_rdata = eng_rdata_reg;
    assign eng_fill = count_reg;
    assign eng_near_full = flags_reg[1];
    assign eng_near_empty = flags_reg[0];

endmodule : queue_device

`default_nettype wire

// File: queue_ctl.sv
/*
 * Queue controller: takes orders from software over apb and runs
 * single register accesses to the queue device over the link.
 * Assumes the device shares pclk and answers reads one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

module queue_ctl import queue_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    queue_link_if.ctl link
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_WAIT = 2'b01
    } hstate_t;

    hstate_t state_reg;
    hstate_t state_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdat_reg;
    logic wr_reg;
    logic rd_reg;
    logic [DATA_W-1:0] resp_reg;
    logic [1:0] acc_reg;
    logic [2:0] istat_reg;
    logic [2:0] istat_next;
    logic [2:0] imask_reg;
    logic [2:0] imask_next;
    logic irq_reg;
    logic dev_irq_q;
    logic [31:0] prdata_reg;
    logic pready_reg;

    // apb decode: one wait state, the take is the pready edge
    wire logic access = psel & penable & ~pready_reg;
    wire logic take_wr = psel & penable & pready_reg & pwrite;
    wire logic busy = (state_reg != H_IDLE) | wr_reg | rd_reg;
    wire logic wr_req = take_wr & (paddr == HOFS_REQ);
    wire logic [ADDR_W-1:0] req_addr = pwdata[REQ_ADDR_LSB +: ADDR_W];
    wire logic req_dir = pwdata[REQ_DIR_BIT];
    wire logic to_data = (req_addr == OFS_DATA);

    // data port accesses gated by the software-set permission
    wire logic not_allowed = to_data &
        (req_dir ? ~acc_reg[ACC_WR_BIT] : ~acc_reg[ACC_RD_BIT]);
    wire logic refuse = wr_req & (busy | not_allowed);
    wire logic launch = wr_req & ~busy & ~not_allowed;
    wire logic done_evt = (launch & req_dir) |
        ((state_reg == H_WAIT) & link.reg_rvalid);
    wire logic dev_rise = link.irq & ~dev_irq_q;

    // sticky events, write one to clear, set wins
    wire logic [2:0] ev = {refuse, dev_rise, done_evt};
    wire logic [2:0] clr = (take_wr & (paddr == HOFS_ISTAT)) ? pwdata[2:0] : 3'h0;
    assign istat_next = (istat_reg & ~clr) | ev;
    assign imask_next = (take_wr & (paddr == HOFS_IMASK)) ? pwdata[2:0] : imask_reg;

    // read selection for the apb answer
    wire logic [31:0] resp_val = {15'h0, link.irq, resp_reg, 7'h0, busy};
    wire logic [31:0] rd_val =
        (paddr == HOFS_RESP) ? resp_val :
        (paddr == HOFS_ISTAT) ? {29'h0, istat_reg} :
        (paddr == HOFS_IMASK) ? {29'h0, imask_reg} :
        (paddr == HOFS_ACCESS) ? {30'h0, acc_reg} :
        32'h0;

    // link sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            H_IDLE: begin
                if (launch & ~req_dir) begin
                    state_next = H_WAIT;
                end
            end
            H_WAIT: begin
                if (link.reg_rvalid) begin
                    state_next = H_IDLE;
                end
            end
            default: state_next = H_IDLE;
        endcase
    end

    // link drive and captured read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= H_IDLE;
            addr_reg <= '0;
            wdat_reg <= '0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            resp_reg <= '0;
        end else begin
            state_reg <= state_next;
            wr_reg <= launch & req_dir;
            rd_reg <= launch & ~req_dir;
            if (launch) begin
                addr_reg <= req_addr;
                wdat_reg <= pwdata[REQ_WDATA_LSB +: DATA_W];
            end
            if ((state_reg == H_WAIT) & link.reg_rvalid) begin
                resp_reg <= link.reg_rdata;
            end
        end
    end

    // software registers, interrupt and apb answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= ACCESS_RESET;
            istat_reg <= 3'h0;
            imask_reg <= 3'h0;
            irq_reg <= 1'b0;
            dev_irq_q <= 1'b0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
        end else begin
            if (take_wr & (paddr == HOFS_ACCESS)) begin
                acc_reg <= pwdata[1:0];
            end
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            irq_reg <= |(istat_next & imask_next);
            dev_irq_q <= link.irq;
            pready_reg <= access;
            if (access) begin
                prdata_reg <= rd_val;
            end
        end
    end

    // outputs straight from flip-flops, pslverr tied low
    assign link.reg_addr = addr_reg;
    assign link.reg_wdata = wdat_reg;
    assign link.reg_wr = wr_reg;
    assign link.reg_rd = rd_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = 1'b0;
    assign irq = irq_reg;

endmodule : queue_ctl

`default_nettype wire

// File: queue_link_sva.sv
/*
 * Checker for the register link between controller and queue device.
 * Assumes one pclk domain; the bench instances it beside the link.
 */
`timescale 1ns/1ps
`default_nettype none

module queue_link_sva import queue_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic irq
);
    // one domain, reset silences every check
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // read answer comes one cycle later and only then
    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without read");
    rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without read");
    // write requests are single pulses, not followed by a read in the next cycle
    wr_pulse_a: assert property (reg_wr |=> !reg_wr && !reg_rd)
        else $error("write strobe not a pulse");
    // field widths of the readable registers
    fill_width_a: assert property (reg_rd && reg_addr == OFS_FILL |=>
        reg_rdata[7] == 1'b0 && reg_rdata <= 8'h40)
        else $error("fill count out of range");
    flush_self_a: assert property (reg_rd && reg_addr == OFS_CTRL |=>
        reg_rdata[BIT_FLUSH] == 1'b0)
        else $error("flush bit reads back set");
    wmark_width_a: assert property (reg_rd && reg_addr == OFS_WMARK |=>
        reg_rdata[7:6] == 2'b00)
        else $error("threshold wider than six bits");
    pend_width_a: assert property (reg_rd && reg_addr == OFS_IRQ |=>
        reg_rdata[7:2] == 6'h00)
        else $error("pending has extra bits");
    // summary status bit follows the interrupt line
    status_irq_a: assert property (reg_rd && reg_addr == OFS_STATUS |=>
        reg_rdata[BIT_IRQ] == $past(irq))
        else $error("status irq bit differs from pin");
endmodule : queue_link_sva

`default_nettype wire

// File: testbench.sv
/*
 * Self-checking bench: software over apb drives the controller, which
 * reaches the queue device over the link; a queue model predicts data, fill and flags.
 * Assumes a 200 MHz pclk and the hand-over timing of both ends.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench import queue_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_irq;
    logic eng_push, eng_pop, eng_near_full, eng_near_empty, ovf;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, t;
    logic [7:0] eng_wdata, eng_rdata, rv;
    logic [CNT_W-1:0] eng_fill;
    logic [1:0] pen, msk;
    logic [7:0] q[$];
    int error_cnt, checks_done, cyc, thr;

    queue_link_if link();
    queue_device queue_device_inst (.pclk(pclk), .presetn(presetn), .link(link.dev),
        .eng_push(eng_push), .eng_wdata(eng_wdata), .eng_pop(eng_pop),
        .eng_rdata(eng_rdata), .eng_fill(eng_fill), .eng_near_full(eng_near_full),
        .eng_near_empty(eng_near_empty));
    queue_ctl queue_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(host_irq),
        .link(link.ctl));
    queue_link_sva queue_link_sva_inst (.pclk(pclk), .presetn(presetn),
        .reg_addr(link.reg_addr), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
        .reg_rvalid(link.reg_rvalid), .irq(link.irq));

    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors=%0d checks=%0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // model status byte: irq summary, near full, near empty
    function automatic logic [7:0] st();
        logic nf;
        logic ne;
        nf = (64 - q.size()) <= thr;
        ne = q.size() <= thr;
        return {4'h0, |(pen & msk), 1'b0, nf, ne};
    endfunction : st

    task automatic upd();
        logic [7:0] s;
        s = st();
        pen = pen | s[1:0];
    endtask : upd

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one device register access through the controller
    task automatic dev(input logic w, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        logic [31:0] x;
        apb(1'b1, HOFS_REQ, {15'h0, w, 2'h0, a, d}, x);
        do apb(1'b0, HOFS_RESP, 32'h0, x); while (x[RESP_BUSY_BIT] !== 1'b0);
        r = x[15:8];
    endtask : dev

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        dev(1'b0, a, 8'h00, rv);
        chk(rv, e);
    endtask : rd_chk

    task automatic push(input logic [7:0] d);
        dev(1'b1, OFS_DATA, d, rv);
        if (q.size() == 64) ovf = 1'b1;
        else q.push_back(d);
        upd();
    endtask : push

    task automatic pop_chk();
        dev(1'b0, OFS_DATA, 8'h00, rv);
        chk(rv, (q.size() > 0) ? q.pop_front() : 8'h00);
        upd();
    endtask : pop_chk

    // engine push or pop, then compare its outputs with the model
    task automatic eng(input logic p, input logic [7:0] d);
        logic [7:0] s;
        @(posedge pclk);
        eng_push <= p;
        eng_pop <= !p;
        eng_wdata <= d;
        @(posedge pclk);
        eng_push <= 1'b0;
        eng_pop <= 1'b0;
        @(posedge pclk);
        if (p) q.push_back(d);
        else chk(eng_rdata, q.pop_front());
        upd();
        s = st();
        chk({eng_fill, eng_near_full, eng_near_empty}, {CNT_W'(q.size()), s[1:0]});
    endtask : eng

    // main sequence
    initial begin
        {psel, penable, pwrite, eng_push, eng_pop, ovf} = '0;
        {paddr, pwdata, eng_wdata, pen, msk} = '0;
        presetn = 1'b0;
        void'($urandom(20190));
        thr = 62;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        upd();
        rd_chk(OFS_WMARK, WMARK_RESET);
        rd_chk(OFS_STATUS, st());
        rd_chk(OFS_IRQ, {6'h0, pen});
        apb(1'b0, HOFS_ACCESS, 32'h0, t);
        chk(t, 32'h3);
        thr = $urandom_range(30, 1);
        dev(1'b1, OFS_WMARK, thr[7:0], rv);
        dev(1'b1, OFS_IEN, 8'h83, rv);
        msk = 2'h3;
        for (int i = 0; i < 64; i++) begin
            push($urandom);
            rd_chk(OFS_STATUS, st());
            rd_chk(OFS_FILL, q.size());
            if (q.size() == 32) begin
                dev(1'b1, OFS_IRQ, 8'h03, rv);
                pen = 2'h0;
                rd_chk(OFS_STATUS, st());
            end
        end
        push($urandom);
        rd_chk(OFS_FAULT, {3'h0, ovf, 4'h0});
        rd_chk(OFS_FILL, 8'h40);
        repeat (65) pop_chk();
        rd_chk(OFS_FAULT, {3'h0, ovf, 4'h0});
        for (int i = 0; i < 6; i++) eng(i < 3, $urandom);
        for (int i = 0; i < 3; i++) eng(1'b1, $urandom);
        repeat (3) pop_chk();
        repeat (5) push($urandom);
        dev(1'b1, OFS_CTRL, 8'h01, rv);
        q.delete();
        ovf = 1'b0;
        upd();
        rd_chk(OFS_FILL, 8'h00);
        rd_chk(OFS_FAULT, {3'h0, ovf, 4'h0});
        rd_chk(OFS_CTRL, 8'h00);
        pop_chk();
        dev(1'b1, OFS_IEN, 8'h03, rv);
        msk = 2'h0;
        rd_chk(OFS_STATUS, st());
        apb(1'b1, HOFS_ISTAT, 32'h7, t);
        apb(1'b1, HOFS_IMASK, 32'h3, t);
        dev(1'b1, OFS_IEN, 8'h83, rv);
        msk = 2'h3;
        repeat (2) @(posedge pclk);
        chk(host_irq, 1'b1);
        apb(1'b0, HOFS_ISTAT, 32'h0, t);
        chk(t[1:0], 2'h3);
        apb(1'b1, HOFS_ISTAT, 32'h7, t);
        repeat (2) @(posedge pclk);
        chk(host_irq, 1'b0);
        apb(1'b1, HOFS_ACCESS, 32'h0, t);
        dev(1'b1, OFS_DATA, 8'h5a, rv);
        apb(1'b0, HOFS_ISTAT, 32'h0, t);
        chk(t[HIRQ_REFUSED], 1'b1);
        chk(pslverr, 1'b0);
        apb(1'b1, HOFS_ACCESS, 32'h3, t);
        rd_chk(OFS_FILL, q.size());
        // nv read style: arguments first, then reads only
        apb(1'b1, HOFS_ISTAT, 32'h7, t);
        apb(1'b1, HOFS_ACCESS, 32'h1, t);
        push(8'ha5);
        dev(1'b0, OFS_DATA, 8'h00, rv);
        apb(1'b0, HOFS_ISTAT, 32'h0, t);
        chk(t[HIRQ_REFUSED], 1'b1);
        apb(1'b1, HOFS_ISTAT, 32'h7, t);
        apb(1'b1, HOFS_ACCESS, 32'h2, t);
        dev(1'b1, OFS_DATA, 8'h3c, rv);
        apb(1'b0, HOFS_ISTAT, 32'h0, t);
        chk(t[HIRQ_REFUSED], 1'b1);
        pop_chk();
        rd_chk(OFS_FILL, q.size());
        apb(1'b1, HOFS_ACCESS, 32'h3, t);
        // pending bits: software clear, then software set
        dev(1'b1, OFS_IRQ, 8'h03, rv);
        pen = 2'h0;
        upd();
        rd_chk(OFS_IRQ, {6'h0, pen});
        dev(1'b1, OFS_IRQ, 8'h82, rv);
        pen = pen | 2'h2;
        rd_chk(OFS_IRQ, {6'h0, pen});
        apb(1'b0, 12'h0f0, 32'h0, t);
        chk(t, 32'h0);
        end_sim();
    end
endmodule : testbench

`default_nettype wire
